/* File: tacc_fifo.sv */
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module tacc_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic flush_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  // pointers wrap naturally, so depth must be a power of two
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // storage flops
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wptr; // next slot to write
  logic [AW-1:0] rptr; // oldest slot
  logic [AW:0] count; // words held
  logic [AW-1:0] next_wptr;
  logic [AW-1:0] next_rptr;
  logic [AW:0] next_count;
  logic do_wr;
  logic do_rd;

  // honest flags straight from the count
  assign wr_ready_o = (count != FULL_CNT);
  assign rd_valid_o = (count != '0);
  assign rd_data_o = mem[rptr];
  assign count_o = count;

  // next pointers, count and storage
  always_comb begin
    do_wr = wr_valid_i & wr_ready_o;
    do_rd = rd_valid_o & rd_ready_i;
    next_mem = mem;
    next_wptr = wptr + AW'(do_wr);
    next_rptr = rptr + AW'(do_rd);
    next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    if (do_wr) begin
      next_mem[wptr] = wr_data_i;
    end
    if (flush_i) begin
      // flush drops everything held, a write in the same cycle included
      next_wptr = '0;
      next_rptr = '0;
      next_count = '0;
    end
  end

  // register only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      mem <= next_mem;
    end
  end
endmodule
`default_nettype wire

/* File: tacc_pkg.sv */
// constants and state encoding shared by the tape adapter channel control block
package tacc_pkg;

  // data format
  localparam int WORD_W = 30; // computer channel word width
  localparam int CHAR_W = 6; // information bits per character
  localparam int TCHAR_W = 7; // tape character, parity on top
  localparam int CHARS_PER_WORD = 5; // characters packed in one word
  localparam int BLK_WORDS = 24; // words in one blockette
  localparam int BLK_CHARS = BLK_WORDS * CHARS_PER_WORD; // 120 tape lines
  localparam int UNITS = 7; // magnetic_tape_unit count
  localparam int COND_W = 4; // special status lines per unit
  localparam int INSTR_W = 4; // tape instruction lines
  localparam int CMD_W = 15; // used command word bits

  // command word fields
  localparam int CMD_ADDR_LSB = 0; // one bit per unit address, several may be set, bits 0..6
  localparam int CMD_XOUT_BIT = 7; // transfer data out
  localparam int CMD_XIN_BIT = 8; // transfer data in
  localparam int CMD_INSTR_LSB = 9; // tape instruction, bits 9..12
  localparam int CMD_SSR_BIT = 13; // special status request
  localparam int CMD_MCLR_BIT = 14; // master clear

  // status word fields
  localparam int ST_READY_LSB = 0; // unit ready flags, bits 0..6
  localparam int ST_COND_LSB = 7; // special status lines, bits 7..10
  localparam int ST_SSR_BIT = 14; // special status reply

  // index walk limits
  localparam logic [4:0] WIX_FIRST = 5'h00; // word 0
  localparam logic [4:0] WIX_LAST = 5'h17; // word 23
  localparam logic [4:0] WIX_END = 5'h18; // one past word 23
  localparam logic [2:0] CIX_TOP = 3'h4; // character 4
  localparam logic [2:0] CIX_BOT = 3'h0; // character 0

  // buffering
  localparam int FIFO_DEPTH = 16; // words of elastic storage
  localparam int FIFO_MARGIN = 2; // room kept for the registered ready

  // command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FILL = 3'b001,
    ST_SEND = 3'b010,
    ST_RECV = 3'b011,
    ST_DRAIN = 3'b100,
    ST_DONE = 3'b101
  } tacc_state_e;

endpackage

/* File: tacc_properties.sv */
// port-level assertions for the tape adapter channel control block
`timescale 1ns/10ps
`default_nettype none
module tacc_properties
  import tacc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ctl_input_ready_i,
  input wire logic ctl_output_resume_o,
  input wire logic [WORD_W-1:0] ctl_status_word_o,
  input wire logic ctl_input_resume_o,
  input wire logic din_valid_o,
  input wire logic [WORD_W-1:0] din_word_o,
  input wire logic din_ready_i,
  input wire logic tape_instr_strobe_o,
  input wire logic tape_char_valid_o,
  input wire logic [TCHAR_W-1:0] tape_char_o,
  input wire logic tape_char_ready_i,
  input wire logic tape_char_ready_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // every tape line leaves with an odd count of ones
  AST_ODD_PARITY: assert property (tape_char_valid_o |-> ^tape_char_o) else $error("even tape parity");
  // a line offered to a stalled unit must not change or vanish
  AST_CHAR_HOLD: assert property (
    tape_char_valid_o && !tape_char_ready_i |=> tape_char_valid_o && $stable(tape_char_o))
    else $error("tape char dropped");
  AST_DIN_HOLD: assert property (din_valid_o && !din_ready_i |=> din_valid_o && $stable(din_word_o))
    else $error("input word dropped");
  AST_STATUS_UNUSED: assert property (
    ctl_input_resume_o |-> ctl_status_word_o[29:15] == 0 && ctl_status_word_o[13:11] == 0)
    else $error("unused status bits set");
  // conditions only ever travel with the reply flag
  AST_SPEC_GATED: assert property (
    ctl_input_resume_o && !ctl_status_word_o[ST_SSR_BIT] |-> ctl_status_word_o[10:7] == 0)
    else $error("conditions without reply flag");
  AST_STROBE_BUSY: assert property (tape_instr_strobe_o |-> busy_o ##1 !tape_instr_strobe_o)
    else $error("strobe outside busy");
  AST_FREE_RESUME: assert property ($fell(busy_o) |-> $rose(ctl_output_resume_o)) else $error("no resume");
  AST_STATUS_ANSWER: assert property ($rose(ctl_input_ready_i) |-> ##[2:6] ctl_input_resume_o)
    else $error("status fetch unanswered");
  // data only moves while a command holds the adapter
  AST_DATA_BUSY: assert property (tape_char_valid_o || tape_char_ready_o || din_valid_o |-> busy_o)
    else $error("data moved while available");
  cover property (ctl_input_resume_o && ctl_status_word_o[ST_SSR_BIT]);
  cover property (tape_char_valid_o && !tape_char_ready_i);
  cover property (din_valid_o && din_ready_i);
endmodule
bind tacc_top tacc_properties u_props (.*);
`default_nettype wire

/* File: tacc_tape_model.sv */
// behavioural magnetic_tape_unit side of the tape character streams
`timescale 1ns/10ps
`default_nettype none
module tacc_tape_model
  import tacc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic rd_i,
  input wire logic in_valid_i,
  input wire logic [TCHAR_W-1:0] in_char_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [TCHAR_W-1:0] out_char_o,
  input wire logic out_ready_i,
  output logic sentinel_o
);
  logic [TCHAR_W-1:0] rx_mem [0:BLK_CHARS-1]; // lines as recorded
  int rx_cnt; // lines taken
  int tx_cnt; // lines sent back
  int run; // consecutive sentinel lines
  logic [3:0] tick; // paces the stalls
  logic [5:0] nxt; // next line to send
  // stalls every other pair of cycles, so the adapter must hold its offered line through each stall
  assign in_ready_o = !tick[1];
  assign nxt = 6'(BLK_CHARS - 1 - tx_cnt);
  assign out_valid_o = tx_cnt < BLK_CHARS; // exactly one blockette
  // idle lines show garbage so a stale sample is caught
  assign out_char_o = out_valid_o ? {~^nxt, nxt} : {^nxt, ~nxt};
  always_ff @(posedge clk_i) begin
    tick <= reset_n_i ? tick + 4'h1 : 4'h0; // restart the stall pattern, never left unknown
    if (!reset_n_i || load_i) begin
      rx_cnt <= 0;
      run <= 0;
      sentinel_o <= 1'b0;
      tx_cnt <= (reset_n_i && rd_i) ? 0 : BLK_CHARS;
    end else begin
      if (out_valid_o && out_ready_i) begin
        tx_cnt <= tx_cnt + 1;
      end
      if (in_valid_i && in_ready_o) begin
        rx_mem[rx_cnt] <= in_char_i;
        rx_cnt <= rx_cnt + 1;
        run <= (in_char_i[5:0] == 6'h3C) ? run + 1 : 0;
        if (in_char_i[5:0] == 6'h3C && run >= 11) begin
          sentinel_o <= 1'b1; // twelve in a row flag end-of-file
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tacc_top.sv */
// tape_system_adapter control channel, blockette format and tape data sequencing
`timescale 1ns/10ps
`default_nettype none
module tacc_top
  import tacc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control channel from the computer, asynchronous pins
  input wire logic ctl_output_ready_i,
  input wire logic [WORD_W-1:0] ctl_cmd_word_i,
  output logic ctl_output_resume_o,
  input wire logic ctl_input_ready_i,
  output logic [WORD_W-1:0] ctl_status_word_o,
  output logic ctl_input_resume_o,
  // data channel, computer to adapter
  input wire logic dout_valid_i,
  input wire logic [WORD_W-1:0] dout_word_i,
  output logic dout_ready_o,
  // data channel, adapter to computer
  output logic din_valid_o,
  output logic [WORD_W-1:0] din_word_o,
  input wire logic din_ready_i,
  // tape unit instruction lines
  output logic [UNITS-1:0] tape_unit_select_o,
  output logic [INSTR_W-1:0] tape_instr_o,
  output logic tape_instr_strobe_o,
  input wire logic [UNITS-1:0] tape_ready_i,
  input wire logic [UNITS*COND_W-1:0] tape_cond_i,
  // tape character streams
  output logic tape_char_valid_o,
  output logic [TCHAR_W-1:0] tape_char_o,
  input wire logic tape_char_ready_i,
  input wire logic tape_char_valid_i,
  input wire logic [TCHAR_W-1:0] tape_char_i,
  output logic tape_char_ready_o,
  output logic busy_o
);
  localparam int SYNC_W = 2 + UNITS + UNITS * COND_W + CMD_W;
  localparam int FAW = $clog2(DEPTH);
  localparam logic [FAW:0] FILL_LIMIT = (FAW+1)'(DEPTH - FIFO_MARGIN);

  // pick one character out of a packed word
  function automatic logic [CHAR_W-1:0] char_of(input logic [WORD_W-1:0] w, input logic [2:0] idx);
    char_of = w[CHAR_W*idx +: CHAR_W];
  endfunction

  // prepend odd parity so the seven bits hold an odd count of ones
  function automatic logic [TCHAR_W-1:0] with_parity(input logic [CHAR_W-1:0] c);
    with_parity = {~^c, c};
  endfunction

  // or together the condition lines of every addressed unit
  function automatic logic [COND_W-1:0] pick_cond(input logic [UNITS-1:0] addr,
                                                   input logic [UNITS*COND_W-1:0] cond);
    pick_cond = '0;
    for (int u = 0; u < UNITS; u++) begin
      if (addr[u]) begin
        pick_cond = pick_cond | cond[u*COND_W +: COND_W];
      end
    end
  endfunction

  // two-stage synchroniser for the control channel, unit ready and condition inputs
  logic [SYNC_W-1:0] sync_meta; // first stage, read only by sync_hold
  logic [SYNC_W-1:0] sync_hold; // second stage, safe to use
  logic prev_out_rdy; // edge detect history
  logic prev_in_rdy;
  logic s_out_rdy;
  logic s_in_rdy;
  logic [UNITS-1:0] s_ready;
  logic [UNITS*COND_W-1:0] s_cond;
  logic [CMD_W-1:0] s_cmd;

  assign s_out_rdy = sync_hold[0];
  assign s_in_rdy = sync_hold[1];
  assign s_ready = sync_hold[2 +: UNITS];
  assign s_cond = sync_hold[2+UNITS +: UNITS*COND_W];
  assign s_cmd = sync_hold[2+UNITS+UNITS*COND_W +: CMD_W];

  // synchroniser and edge history flops
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync_meta <= '0;
      sync_hold <= '0;
      prev_out_rdy <= 1'b0;
      prev_in_rdy <= 1'b0;
    end else begin
      sync_meta <= {ctl_cmd_word_i[CMD_W-1:0], tape_cond_i, tape_ready_i, ctl_input_ready_i, ctl_output_ready_i};
      sync_hold <= sync_meta;
      prev_out_rdy <= s_out_rdy;
      prev_in_rdy <= s_in_rdy;
    end
  end

  // sequencer and datapath state
  tacc_state_e state, next_state;
  logic busy, next_busy; // adapter not available
  logic [4:0] wix, next_wix; // word index into the blockette store
  logic [2:0] cix, next_cix; // character index within the word
  logic [4:0] acc, next_acc; // words accepted from the computer
  logic [WORD_W-1:0] store [BLK_WORDS]; // whole blockette, needed to reverse order
  logic [WORD_W-1:0] next_store [BLK_WORDS];
  logic [COND_W-1:0] spec_bits, next_spec_bits; // latched condition lines
  logic spec_valid, next_spec_valid; // last command was a status request
  logic out_resume, next_out_resume;
  logic in_resume, next_in_resume;
  logic [WORD_W-1:0] status_word, next_status_word;
  logic [UNITS-1:0] unit_sel, next_unit_sel;
  logic [INSTR_W-1:0] instr, next_instr;
  logic instr_strobe, next_instr_strobe;
  logic tc_valid, next_tc_valid;
  logic [TCHAR_W-1:0] tc_data, next_tc_data;
  logic tc_ready, next_tc_ready;
  logic dr_ready, next_dr_ready;
  logic di_valid, next_di_valid;
  logic [WORD_W-1:0] di_word, next_di_word;

  // fifo hookup
  logic f_flush;
  logic f_wr_valid;
  logic f_wr_ready;
  logic [WORD_W-1:0] f_wr_data;
  logic f_rd_valid;
  logic f_rd_ready;
  logic [WORD_W-1:0] f_rd_data;
  logic [FAW:0] f_count;
  logic out_edge;
  logic in_edge;
  logic tc_take;
  logic rc_take;

  // elastic buffer on the computer side; drains into the store on writes
  // and fills from the store on reads, so a stalled computer really backs it up
  tacc_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .flush_i(f_flush),
    .wr_valid_i(f_wr_valid),
    .wr_ready_o(f_wr_ready),
    .wr_data_i(f_wr_data),
    .rd_valid_o(f_rd_valid),
    .rd_ready_i(f_rd_ready),
    .rd_data_o(f_rd_data),
    .count_o(f_count)
  );

  // next-state logic for the whole sequencer
  always_comb begin
    next_state = state;
    next_busy = busy;
    next_wix = wix;
    next_cix = cix;
    next_acc = acc;
    next_store = store;
    next_spec_bits = spec_bits;
    next_spec_valid = spec_valid;
    next_status_word = status_word;
    next_unit_sel = unit_sel;
    next_instr = instr;
    next_instr_strobe = 1'b0;
    next_tc_valid = tc_valid;
    next_tc_data = tc_data;
    next_tc_ready = tc_ready;
    next_di_valid = di_valid;
    next_di_word = di_word;
    f_flush = 1'b0;
    f_wr_valid = 1'b0;
    f_wr_data = '0;
    f_rd_ready = 1'b0;
    out_edge = s_out_rdy & ~prev_out_rdy;
    in_edge = s_in_rdy & ~prev_in_rdy;
    tc_take = tc_valid & tape_char_ready_i;
    rc_take = tape_char_valid_i & tc_ready;

    // fifo steering by phase
    if (state == ST_FILL) begin
      f_wr_valid = dout_valid_i & dr_ready; // margin keeps wr_ready high here
      f_wr_data = dout_word_i;
      f_rd_ready = 1'b1;
    end else if (state == ST_DRAIN) begin
      f_wr_valid = (wix != WIX_END);
      f_wr_data = store[wix];
      f_rd_ready = ~di_valid | din_ready_i;
    end

    case (state)
      ST_IDLE: begin
        // a command edge while busy never reaches here, so it is dropped
        if (out_edge && !busy) begin
          next_busy = 1'b1;
          if (s_cmd[CMD_MCLR_BIT]) begin
            // master clear clears spec_valid and di_valid, flushes the fifo and reports done
            next_spec_valid = 1'b0;
            next_di_valid = 1'b0;
            f_flush = 1'b1;
            next_state = ST_DONE;
          end else if (s_cmd[CMD_SSR_BIT]) begin
            // latch conditions only; no tape line or data path moves
            next_spec_bits = pick_cond(s_cmd[CMD_ADDR_LSB +: UNITS], s_cond);
            next_spec_valid = 1'b1;
            next_state = ST_DONE;
          end else begin
            // field layout of the command word
            next_spec_valid = 1'b0;
            next_unit_sel = s_cmd[CMD_ADDR_LSB +: UNITS]; // several units allowed
            next_instr = s_cmd[CMD_INSTR_LSB +: INSTR_W];
            next_instr_strobe = 1'b1;
            if (s_cmd[CMD_XOUT_BIT]) begin
              next_acc = WIX_FIRST;
              next_wix = WIX_FIRST;
              next_state = ST_FILL;
            end else if (s_cmd[CMD_XIN_BIT]) begin
              next_wix = WIX_LAST; // first tape line lands at word 23 char 4
              next_cix = CIX_TOP;
              next_tc_ready = 1'b1;
              next_state = ST_RECV;
            end else begin
              next_state = ST_DONE; // no data moves, resume at once
            end
          end
        end
      end
      ST_FILL: begin
        // computer sends word 0 first; exactly 24 words are taken
        if (dout_valid_i && dr_ready) begin
          next_acc = acc + 5'h01;
        end
        if (f_rd_valid) begin
          next_store[wix] = f_rd_data;
          if (wix == WIX_LAST) begin
            next_wix = WIX_LAST;
            next_cix = CIX_TOP;
            next_tc_valid = 1'b1;
            next_tc_data = with_parity(char_of(f_rd_data, CIX_TOP));
            next_state = ST_SEND;
          end else begin
            next_wix = wix + 5'h01;
          end
        end
      end
      ST_SEND: begin
        // walk down characters, then words, to word 0 char 0
        if (tc_take) begin
          if (wix == WIX_FIRST && cix == CIX_BOT) begin
            next_tc_valid = 1'b0;
            next_state = ST_DONE; // blockette is in the unit buffer
          end else if (cix == CIX_BOT) begin
            next_wix = wix - 5'h01;
            next_cix = CIX_TOP;
            next_tc_data = with_parity(char_of(store[wix - 5'h01], CIX_TOP));
          end else begin
            next_cix = cix - 3'h1;
            next_tc_data = with_parity(char_of(store[wix], cix - 3'h1));
          end
        end
      end
      ST_RECV: begin
        // parity is dropped, six information bits are kept
        if (rc_take) begin
          next_store[wix][CHAR_W*cix +: CHAR_W] = tape_char_i[CHAR_W-1:0];
          if (wix == WIX_FIRST && cix == CIX_BOT) begin
            next_tc_ready = 1'b0; // 120 lines taken, no more
            next_wix = WIX_FIRST;
            next_state = ST_DRAIN;
          end else if (cix == CIX_BOT) begin
            next_wix = wix - 5'h01;
            next_cix = CIX_TOP;
          end else begin
            next_cix = cix - 3'h1;
          end
        end
      end
      ST_DRAIN: begin
        // hand words 0..23 to the computer through the fifo
        if (f_wr_valid && f_wr_ready) begin
          next_wix = wix + 5'h01;
        end
        if (wix == WIX_END && !f_rd_valid && !di_valid) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_busy = 1'b0; // available again as resume goes out
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // registered ready towards the computer; margin covers the one-cycle lag
    next_dr_ready = (next_state == ST_FILL) && (next_acc != WIX_END) && (f_count < FILL_LIMIT);

    // output stage towards the computer
    if (f_rd_ready && f_rd_valid && state == ST_DRAIN) begin
      next_di_valid = 1'b1;
      next_di_word = f_rd_data;
    end else if (din_ready_i) begin
      next_di_valid = 1'b0;
    end

    // output resume: raised on completion, held until output ready drops
    if (state == ST_DONE) begin
      next_out_resume = 1'b1;
    end else if (!s_out_rdy) begin
      next_out_resume = 1'b0;
    end else begin
      next_out_resume = out_resume;
    end

    // status fetch answered at any time, held until input ready drops
    if (in_edge) begin
      next_status_word = '0;
      next_status_word[ST_READY_LSB +: UNITS] = s_ready;
      if (spec_valid) begin
        next_status_word[ST_COND_LSB +: COND_W] = spec_bits;
        next_status_word[ST_SSR_BIT] = 1'b1;
      end
      next_in_resume = 1'b1;
    end else if (!s_in_rdy) begin
      next_in_resume = 1'b0;
    end else begin
      next_in_resume = in_resume;
    end
  end

  // register only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      wix <= WIX_FIRST;
      cix <= CIX_BOT;
      acc <= WIX_FIRST;
      spec_bits <= '0;
      spec_valid <= 1'b0;
      out_resume <= 1'b0;
      in_resume <= 1'b0;
      status_word <= '0;
      unit_sel <= '0;
      instr <= '0;
      instr_strobe <= 1'b0;
      tc_valid <= 1'b0;
      tc_data <= '0;
      tc_ready <= 1'b0;
      dr_ready <= 1'b0;
      di_valid <= 1'b0;
      di_word <= '0;
      for (int i = 0; i < BLK_WORDS; i++) begin
        store[i] <= '0;
      end
    end else begin
      state <= next_state;
      busy <= next_busy;
      wix <= next_wix;
      cix <= next_cix;
      acc <= next_acc;
      spec_bits <= next_spec_bits;
      spec_valid <= next_spec_valid;
      out_resume <= next_out_resume;
      in_resume <= next_in_resume;
      status_word <= next_status_word;
      unit_sel <= next_unit_sel;
      instr <= next_instr;
      instr_strobe <= next_instr_strobe;
      tc_valid <= next_tc_valid;
      tc_data <= next_tc_data;
      tc_ready <= next_tc_ready;
      dr_ready <= next_dr_ready;
      di_valid <= next_di_valid;
      di_word <= next_di_word;
      store <= next_store;
    end
  end

  // every output straight from a flop
  assign ctl_output_resume_o = out_resume;
  assign ctl_input_resume_o = in_resume;
  assign ctl_status_word_o = status_word;
  assign dout_ready_o = dr_ready;
  assign din_valid_o = di_valid;
  assign din_word_o = di_word;
  assign tape_unit_select_o = unit_sel;
  assign tape_instr_o = instr;
  assign tape_instr_strobe_o = instr_strobe;
  assign tape_char_valid_o = tc_valid;
  assign tape_char_o = tc_data;
  assign tape_char_ready_o = tc_ready;
  assign busy_o = busy;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the tape adapter channel control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tacc_pkg::*;
  localparam logic [27:0] COND = 28'h7654312; // fixed condition nibbles
  logic clk_i = 1'b0, reset_n_i = 1'b0, ctl_output_ready_i = 1'b0, ctl_input_ready_i = 1'b0;
  logic [WORD_W-1:0] ctl_cmd_word_i = '0, dout_word_i = '0;
  logic dout_valid_i = 1'b0, din_ready_i = 1'b0, load = 1'b0, rd = 1'b0;
  logic [UNITS-1:0] tape_ready_i = 7'h55;
  wire logic [UNITS*COND_W-1:0] tape_cond_i;
  logic ctl_output_resume_o, ctl_input_resume_o, dout_ready_o, din_valid_o, tape_instr_strobe_o, busy_o;
  logic [WORD_W-1:0] ctl_status_word_o, din_word_o;
  logic [UNITS-1:0] tape_unit_select_o;
  logic [INSTR_W-1:0] tape_instr_o;
  logic tape_char_valid_o, tape_char_ready_i, tape_char_valid_i, tape_char_ready_o, sentinel;
  logic [TCHAR_W-1:0] tape_char_o, tape_char_i;
  int err_count = 0, n_tests = 0, cyc, strb, n, stalls;
  // status, master clear, multi-unit and no-data commands
  logic [CMD_W-1:0] rows [11] = '{15'h2001, 15'h2002, 15'h2004, 15'h2008, 15'h2010, 15'h2020,
    15'h2040, 15'h2003, 15'h4000, 15'h2000, 15'h0408}; // unit 3 queried before its no-data command
  assign tape_cond_i = COND | 28'(sentinel); // end-of-file patched to unit 0 line W
  always #2.5 clk_i = ~clk_i;
  tacc_top #(.DEPTH(4)) DUT (.*);
  tacc_tape_model u_tape (.clk_i, .reset_n_i, .load_i(load), .rd_i(rd), .in_valid_i(tape_char_valid_o),
    .in_char_i(tape_char_o), .in_ready_o(tape_char_ready_i), .out_valid_o(tape_char_valid_i),
    .out_char_o(tape_char_i), .out_ready_i(tape_char_ready_o), .sentinel_o(sentinel));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait; every step lands 1 ns after the edge
  task automatic await(ref logic s, input logic lvl, output int k);
    k = 0;
    while (s !== lvl) begin
      @(posedge clk_i);
      #1;
      k++;
      if (k > 4000) begin
        err_count++;
        wrap_up();
      end
    end
  endtask
  task automatic cmd(input logic [CMD_W-1:0] w);
    ctl_cmd_word_i = 30'(w);
    ctl_output_ready_i = 1'b1;
    cyc = 0;
    strb = 0;
    while (ctl_output_resume_o !== 1'b1 && cyc < 4000) begin
      @(posedge clk_i);
      #1;
      cyc++;
      strb += int'(tape_instr_strobe_o);
    end
    if (cyc >= 4000) begin
      err_count++;
      wrap_up();
    end
    ctl_output_ready_i = 1'b0; // word and ready held until resume
    await(ctl_output_resume_o, 1'b0, n);
  endtask
  task automatic stat(input logic [WORD_W-1:0] exp);
    ctl_input_ready_i = 1'b1;
    await(ctl_input_resume_o, 1'b1, n);
    chk("status", ctl_status_word_o, exp);
    ctl_input_ready_i = 1'b0;
    await(ctl_input_resume_o, 1'b0, n);
  endtask
  function automatic logic [WORD_W-1:0] exp_st(input logic [CMD_W-1:0] w);
    logic [WORD_W-1:0] s;
    s = 30'(tape_ready_i);
    for (int u = 0; u < UNITS; u++) begin
      if (w[CMD_SSR_BIT] && w[u]) s[10:7] = s[10:7] | tape_cond_i[4*u +: 4];
    end
    s[ST_SSR_BIT] = w[CMD_SSR_BIT];
    return s;
  endfunction
  function automatic logic [WORD_W-1:0] word_of(input int i, input logic sent);
    for (int c = 0; c < CHARS_PER_WORD; c++) word_of[6*c +: 6] = sent ? 6'h3C : 6'(5*i + c);
  endfunction
  task automatic blk(input logic wr, input logic sent);
    load = 1'b1; // unit restarts recording from its start
    rd = !wr;
    @(posedge clk_i);
    #1;
    load = 1'b0;
    stalls = 0;
    fork
      cmd(wr ? 15'h0281 : 15'h1101);
      for (int i = 0; i < BLK_WORDS; i++) begin // buffer only for data commands
        if (wr) begin
          dout_valid_i = 1'b1;
          dout_word_i = word_of(i, sent);
          await(dout_ready_o, 1'b1, n);
          stalls += n;
          @(posedge clk_i);
          #1;
        end else begin
          await(din_valid_o, 1'b1, n);
          repeat (i % 3) begin
            @(posedge clk_i);
            #1;
          end
          chk("din word", din_word_o, word_of(i, 1'b0));
          din_ready_i = 1'b1;
          @(posedge clk_i);
          #1;
          din_ready_i = 1'b0;
        end
      end
    join
    dout_valid_i = 1'b0;
    if (wr) chk("lines", 30'(u_tape.rx_cnt), 30'(BLK_CHARS));
    if (wr && !sent) chk("refusals", 30'(stalls > 0), 30'h1);
    for (int k = 0; wr && !sent && k < BLK_CHARS; k++) begin
      chk("tape line", 30'(u_tape.rx_mem[k]), 30'({~^6'(119 - k), 6'(119 - k)}));
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    foreach (rows[i]) begin
      cmd(rows[i]);
      chk("strobes", 30'(strb), 30'(!(rows[i][CMD_SSR_BIT] | rows[i][CMD_MCLR_BIT])));
      chk("quick resume", 30'(cyc < 8), 30'h1);
      chk("busy", 30'(busy_o), 30'h0);
      if (strb == 1) chk("unit", 30'({tape_instr_o, tape_unit_select_o}), 30'({rows[i][12:9], rows[i][6:0]}));
      stat(exp_st(rows[i]));
    end
    blk(1'b1, 1'b0);
    blk(1'b0, 1'b0);
    blk(1'b1, 1'b1); // whole sentinel blockette
    chk("sentinel", 30'(sentinel), 30'h1);
    cmd(15'h2001);
    stat(exp_st(15'h2001));
    reset_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("reset", 30'({busy_o, ctl_output_resume_o, din_valid_o, tape_char_valid_o}), 30'h0);
    reset_n_i = 1'b1;
    stat(exp_st(15'h0000));
    wrap_up();
  end
endmodule
`default_nettype wire
